// ==== verilog/atomic_pkg.sv ====
// package of shared constants and types for the atomic guest link
package atomic_pkg;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned LINE_BYTES = 32;
  localparam int unsigned LINE_LSB   = $clog2(LINE_BYTES);
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned LINE_WORDS = LINE_BYTES / WORD_BYTES;
  localparam int unsigned CLEAR_BYTES = 16;
  localparam logic [DATA_W-1:0] CLEAR_VALUE = 32'h0000_0000;
  // cycles the lock line must settle before a request, to cover the adapter's sync
  localparam int unsigned LOCK_LEAD   = 2;

  typedef enum logic [1:0]
  {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_CLEAR = 2'h2
  } guest_op_t;
endpackage

// ==== verilog/atomic_link_if.sv ====
// interface joining the guest end and the adapter end of the atomic link
interface atomic_link_if;
  logic                             atomic_lock_line_n;
  logic                             req_valid;
  atomic_pkg::guest_op_t            req_op;
  logic [atomic_pkg::ADDR_W-1:0]    req_addr;
  logic [atomic_pkg::DATA_W-1:0]    req_wdata;
  logic                             req_ready;
  logic                             rsp_valid;
  logic [atomic_pkg::DATA_W-1:0]    rsp_rdata;

  modport adapter
  (
    input  atomic_lock_line_n,
    input  req_valid,
    input  req_op,
    input  req_addr,
    input  req_wdata,
    output req_ready,
    output rsp_valid,
    output rsp_rdata
  );

  modport guest
  (
    output atomic_lock_line_n,
    output req_valid,
    output req_op,
    output req_addr,
    output req_wdata,
    input  req_ready,
    input  rsp_valid,
    input  rsp_rdata
  );
endinterface

// ==== verilog/atomic_adapter.sv ====
// adapter end: maps guest atomic requests onto memory-bus ownership and lock
module atomic_adapter
(
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  atomic_link_if.adapter                     link,
  input  wire logic                          page_lock_scope,
  output logic                               mem_req_valid,
  output logic                               mem_req_priv,
  output logic                               mem_req_write,
  output logic [atomic_pkg::ADDR_W-1:0]      mem_req_addr,
  output logic [atomic_pkg::DATA_W-1:0]      mem_req_wdata,
  input  wire logic                          mem_req_ready,
  input  wire logic                          mem_rsp_valid,
  input  wire logic [atomic_pkg::DATA_W-1:0] mem_rsp_rdata,
  output logic                               mem_global_lock,
  output logic                               pair_atomic,
  output logic                               clear_done
);
  localparam int unsigned LW = atomic_pkg::ADDR_W - atomic_pkg::LINE_LSB;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_ISSUE = 3'h1,
    ST_WAIT  = 3'h3,
    ST_CLRWR = 3'h7,
    ST_RESP  = 3'h2
  } adp_state_t;

  // pin sync of the active-low lock line
  logic                lock_meta_reg;
  logic                lock_sync_reg;
  logic                lock_req;
  adp_state_t          state_reg,     state_next;
  atomic_pkg::guest_op_t op_reg,      op_next;
  logic [atomic_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [atomic_pkg::DATA_W-1:0] wdata_reg, wdata_next;
  logic [atomic_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  // answer data changes only together with the answer strobe
  logic [atomic_pkg::DATA_W-1:0] rspdata_reg, rspdata_next;
  logic                priv_reg,      priv_next;
  logic                rsp_reg,       rsp_next;
  // locked pair tracking: 0 none, read seen, pair used up
  logic                pair_open_reg, pair_open_next;
  logic                pair_used_reg, pair_used_next;
  logic [LW-1:0]       pair_line_reg, pair_line_next;
  logic                glock_reg,     glock_next;
  logic                pairat_reg,    pairat_next;
  logic                clrdone_reg,   clrdone_next;
  logic [LW-1:0]       req_line;

  assign lock_req  = ~lock_sync_reg;
  assign req_line  = link.req_addr[atomic_pkg::ADDR_W-1:atomic_pkg::LINE_LSB];

  assign link.req_ready = (state_reg == ST_IDLE);
  assign link.rsp_valid = rsp_reg;
  assign link.rsp_rdata = rspdata_reg;
  assign mem_req_valid  = (state_reg == ST_ISSUE) || (state_reg == ST_CLRWR);
  assign mem_req_priv   = priv_reg;
  assign mem_req_write  = (state_reg == ST_CLRWR) || (op_reg == atomic_pkg::OP_WRITE);
  assign mem_req_addr   = addr_reg;
  assign mem_req_wdata  = (state_reg == ST_CLRWR) ? atomic_pkg::CLEAR_VALUE : wdata_reg;
  assign mem_global_lock = glock_reg;
  assign pair_atomic    = pairat_reg;
  assign clear_done     = clrdone_reg;

  always_comb
  begin
    state_next     = state_reg;
    op_next        = op_reg;
    addr_next      = addr_reg;
    wdata_next     = wdata_reg;
    rdata_next     = rdata_reg;
    rspdata_next   = rspdata_reg;
    priv_next      = priv_reg;
    rsp_next       = 1'b0;
    pair_open_next = pair_open_reg;
    pair_used_next = pair_used_reg;
    pair_line_next = pair_line_reg;
    glock_next     = glock_reg;
    pairat_next    = pairat_reg;
    clrdone_next   = 1'b0;
    if (!lock_req)
    begin
      // lock released: close any window and drop the global lock
      pair_open_next = 1'b0;
      pair_used_next = 1'b0;
      pairat_next    = 1'b0;
      glock_next     = 1'b0;
    end
    unique case (state_reg)
      ST_IDLE:
      begin
        if (link.req_valid)
        begin
          op_next    = link.req_op;
          addr_next  = link.req_addr;
          wdata_next = link.req_wdata;
          priv_next  = 1'b0;
          state_next = ST_ISSUE;
          if (link.req_op == atomic_pkg::OP_CLEAR)
          begin
            priv_next = 1'b1;
          end
          else if (lock_req)
          begin
            priv_next = 1'b1;
            if (page_lock_scope)
            begin
              glock_next = 1'b1;
            end
            if (link.req_op == atomic_pkg::OP_READ && !pair_open_reg && !pair_used_reg)
            begin
              // first locked read opens a one-line pair window
              pair_open_next = 1'b1;
              pair_line_next = req_line;
              pairat_next    = 1'b1;
            end
            else if (link.req_op == atomic_pkg::OP_WRITE && pair_open_reg
                     && req_line == pair_line_reg)
            begin
              // first write closes the pair, later ones are outside it
              pair_open_next = 1'b0;
              pair_used_next = 1'b1;
            end
            else
            begin
              pair_open_next = 1'b0;
              pair_used_next = 1'b1;
              pairat_next    = 1'b0;
            end
          end
        end
      end
      ST_ISSUE:
      begin
        if (mem_req_ready)
        begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (mem_rsp_valid)
        begin
          rdata_next = mem_rsp_rdata;
          state_next = (op_reg == atomic_pkg::OP_CLEAR) ? ST_CLRWR : ST_RESP;
        end
      end
      ST_CLRWR:
      begin
        // owned line: write back the cleared first word
        if (mem_req_ready)
        begin
          clrdone_next = 1'b1;
          state_next   = ST_RESP;
        end
      end
      ST_RESP:
      begin
        rsp_next     = 1'b1;
        rspdata_next = rdata_reg;
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      lock_meta_reg <= 1'b1;
      lock_sync_reg <= 1'b1;
      state_reg     <= ST_IDLE;
      op_reg        <= atomic_pkg::OP_READ;
      addr_reg      <= '0;
      wdata_reg     <= '0;
      rdata_reg     <= '0;
      rspdata_reg   <= '0;
      priv_reg      <= 1'b0;
      rsp_reg       <= 1'b0;
      pair_open_reg <= 1'b0;
      pair_used_reg <= 1'b0;
      pair_line_reg <= '0;
      glock_reg     <= 1'b0;
      pairat_reg    <= 1'b0;
      clrdone_reg   <= 1'b0;
    end
    else
    begin
      lock_meta_reg <= link.atomic_lock_line_n;
      lock_sync_reg <= lock_meta_reg;
      state_reg     <= state_next;
      op_reg        <= op_next;
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      rdata_reg     <= rdata_next;
      rspdata_reg   <= rspdata_next;
      priv_reg      <= priv_next;
      rsp_reg       <= rsp_next;
      pair_open_reg <= pair_open_next;
      pair_used_reg <= pair_used_next;
      pair_line_reg <= pair_line_next;
      glock_reg     <= glock_next;
      pairat_reg    <= pairat_next;
      clrdone_reg   <= clrdone_next;
    end
  end
endmodule

// ==== verilog/atomic_guest.sv ====
// guest end: issues locked read/write pairs, locked groups and clears
module atomic_guest
(
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  atomic_link_if.guest                       link,
  input  wire logic                          cmd_valid,
  input  wire atomic_pkg::guest_op_t         cmd_op,
  input  wire logic [atomic_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [atomic_pkg::DATA_W-1:0] cmd_wdata,
  input  wire logic                          cmd_lock,
  input  wire logic                          cmd_last,
  input  wire logic                          enhanced,
  output logic                               cmd_ready,
  output logic                               done_valid,
  output logic [atomic_pkg::DATA_W-1:0]      done_rdata
);
  typedef enum logic [1:0]
  {
    GS_IDLE = 2'h0,
    GS_LEAD = 2'h1,
    GS_REQ  = 2'h3,
    GS_WAIT = 2'h2
  } guest_state_t;

  guest_state_t                  state_reg, state_next;
  atomic_pkg::guest_op_t         op_reg,    op_next;
  logic [atomic_pkg::ADDR_W-1:0] addr_reg,  addr_next;
  logic [atomic_pkg::DATA_W-1:0] wdata_reg, wdata_next;
  logic                          lock_reg,  lock_next;
  logic                          last_reg,  last_next;
  logic                          done_reg,  done_next;
  logic [atomic_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0]                    lead_reg,  lead_next;
  logic                          lock_cmd;

  // a basic guest has no clear; it needs the lock line for any atomicity
  assign lock_cmd = cmd_lock || (cmd_op == atomic_pkg::OP_CLEAR && !enhanced);

  assign link.atomic_lock_line_n = ~lock_reg;
  assign link.req_valid = (state_reg == GS_REQ);
  assign link.req_op    = op_reg;
  assign link.req_addr  = addr_reg;
  assign link.req_wdata = wdata_reg;
  assign cmd_ready  = (state_reg == GS_IDLE) && (lead_reg == 2'h0);
  assign done_valid = done_reg;
  assign done_rdata = rdata_reg;

  always_comb
  begin
    state_next = state_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    lock_next  = lock_reg;
    last_next  = last_reg;
    lead_next  = (lead_reg != 2'h0) ? lead_reg - 2'h1 : 2'h0;
    done_next  = 1'b0;
    rdata_next = rdata_reg;
    unique case (state_reg)
      GS_IDLE:
      begin
        if (cmd_valid && lead_reg == 2'h0)
        begin
          // a basic guest has no clear; it falls back to a locked read
          op_next    = (cmd_op == atomic_pkg::OP_CLEAR && !enhanced)
                       ? atomic_pkg::OP_READ : cmd_op;
          addr_next  = cmd_addr;
          wdata_next = cmd_wdata;
          lock_next  = lock_cmd;
          last_next  = cmd_last;
          state_next = (lock_cmd != lock_reg) ? GS_LEAD : GS_REQ;
        end
      end
      GS_LEAD:
      begin
        // lock line changed: wait until the far end has it through its sync
        if (lead_reg == 2'h1)
        begin
          state_next = GS_REQ;
        end
      end
      GS_REQ:
      begin
        if (link.req_ready)
        begin
          state_next = GS_WAIT;
        end
      end
      GS_WAIT:
      begin
        // tenure and lock are held until the sequence's last access ends
        if (link.rsp_valid)
        begin
          rdata_next = link.rsp_rdata;
          done_next  = 1'b1;
          state_next = GS_IDLE;
          if (last_reg)
          begin
            lock_next = 1'b0;
          end
        end
      end
    endcase
    if (lock_next != lock_reg)
    begin
      // any lock change holds off the next request for the sync delay
      lead_next = 2'(atomic_pkg::LOCK_LEAD);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= GS_IDLE;
      op_reg    <= atomic_pkg::OP_READ;
      addr_reg  <= '0;
      wdata_reg <= '0;
      lock_reg  <= 1'b0;
      last_reg  <= 1'b0;
      lead_reg  <= 2'h0;
      done_reg  <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      lock_reg  <= lock_next;
      last_reg  <= last_next;
      lead_reg  <= lead_next;
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule

// ==== bench/atomic_link_assertions.sv ====
// concurrent checks on the signals of the atomic guest link
module atomic_link_assertions
(
  input wire logic                          core_clk,
  input wire logic                          sys_rst,
  input wire logic                          atomic_lock_line_n,
  input wire logic                          req_valid,
  input wire atomic_pkg::guest_op_t         req_op,
  input wire logic                          req_ready,
  input wire logic                          rsp_valid,
  input wire logic [atomic_pkg::DATA_W-1:0] rsp_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  wire req_take = req_valid && req_ready;
  property p_busy;
    req_take |=> !req_ready [*2];
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready high while busy");
  property p_late;
    req_take |=> !rsp_valid ##1 !rsp_valid;
  endproperty
  a_late: assert property (p_late)
    else $error("answer too early");
  property p_bound;
    req_take |-> ##[3:200] rsp_valid;
  endproperty
  a_bound: assert property (p_bound)
    else $error("answer missing");
  property p_pulse;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer longer than one cycle");
  property p_idle;
    rsp_valid |-> ##[0:1] req_ready;
  endproperty
  a_idle: assert property (p_idle)
    else $error("adapter not idle after answer");
  property p_one;
    rsp_valid |-> !req_valid;
  endproperty
  a_one: assert property (p_one)
    else $error("request overlaps answer");
  property p_hold;
    !rsp_valid |-> $stable(rsp_rdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved without answer");
  property p_pair_lock;
    req_take && req_op == atomic_pkg::OP_READ && !atomic_lock_line_n |=> !atomic_lock_line_n [*2];
  endproperty
  a_pair_lock: assert property (p_pair_lock)
    else $error("lock dropped inside pair");
  property p_lead;
    $rose(req_valid) && !atomic_lock_line_n |-> !$past(atomic_lock_line_n, 2);
  endproperty
  a_lead: assert property (p_lead)
    else $error("lock line raised too late");
  property p_trail;
    $rose(req_valid) && atomic_lock_line_n |-> $past(atomic_lock_line_n, 2);
  endproperty
  a_trail: assert property (p_trail)
    else $error("lock line released too late");
endmodule

// ==== bench/testbench.sv ====
// self-checking bench joining the guest and adapter ends of the atomic link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk, sys_rst = 1'b1, page_lock_scope = 1'b0, enhanced = 1'b0;
  logic                  mem_req_ready = 1'b0, mem_rsp_valid = 1'b0, cmd_valid = 1'b0;
  logic                  cmd_lock = 1'b0, cmd_last = 1'b0, gl_seen, pa_seen, priv_seen;
  logic [31:0]           mem_rsp_rdata = 32'h0, cmd_addr = 32'h0, cmd_wdata = 32'h0, a, d, last_rd;
  atomic_pkg::guest_op_t cmd_op = atomic_pkg::OP_READ, cur_op = atomic_pkg::OP_READ;
  logic                  mem_req_valid, mem_req_priv, mem_req_write, mem_global_lock;
  logic                  pair_atomic, clear_done, cmd_ready, done_valid;
  logic [31:0]           mem_req_addr, mem_req_wdata, done_rdata;
  logic [31:0]           mem [logic [31:0]];
  logic [31:0]           shad [logic [31:0]];
  int                    seed = 22, n_mismatch = 0, tests_run = 0, cyc = 0, clr_cnt, i;
  atomic_link_if link ();
  atomic_adapter atomic_adapter_i
  (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link.adapter),
    .page_lock_scope(page_lock_scope), .mem_req_valid(mem_req_valid),
    .mem_req_priv(mem_req_priv), .mem_req_write(mem_req_write), .mem_req_addr(mem_req_addr),
    .mem_req_wdata(mem_req_wdata), .mem_req_ready(mem_req_ready),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_rdata(mem_rsp_rdata),
    .mem_global_lock(mem_global_lock), .pair_atomic(pair_atomic), .clear_done(clear_done)
  );
  atomic_guest atomic_guest_i
  (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link.guest), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_lock(cmd_lock),
    .cmd_last(cmd_last), .enhanced(enhanced), .cmd_ready(cmd_ready),
    .done_valid(done_valid), .done_rdata(done_rdata)
  );
  atomic_link_assertions atomic_link_assertions_i
  (
    .core_clk(core_clk), .sys_rst(sys_rst), .atomic_lock_line_n(link.atomic_lock_line_n),
    .req_valid(link.req_valid), .req_op(link.req_op), .req_ready(link.req_ready),
    .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // memory side: random stalls, one answer per access except the clear write-back
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    mem_rsp_valid <= 1'b0;
    mem_req_ready <= 1'($random(seed));
    if (mem_global_lock) gl_seen <= 1'b1;
    if (pair_atomic) pa_seen <= 1'b1;
    if (clear_done) clr_cnt <= clr_cnt + 1;
    if (mem_req_valid && mem_req_ready)
    begin
      if (mem_req_priv) priv_seen <= 1'b1;
      mem_rsp_valid <= !(mem_req_write && cur_op == atomic_pkg::OP_CLEAR);
      mem_rsp_rdata <= mem.exists(mem_req_addr) ? mem[mem_req_addr] : ~mem_req_addr;
      if (mem_req_write) mem[mem_req_addr] = mem_req_wdata;
    end
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  function automatic logic [31:0] exp_rd(input logic [31:0] ad);
    return shad.exists(ad) ? shad[ad] : ~ad;
  endfunction
  task automatic check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clr();
    gl_seen = 1'b0;
    pa_seen = 1'b0;
    priv_seen = 1'b0;
    clr_cnt = 0;
  endtask
  task automatic cmd(input atomic_pkg::guest_op_t op, input logic [31:0] ad, wd,
                     input logic lk, ls, en);
    int n;
    n = 0;
    cur_op <= op;
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_wdata <= wd;
    cmd_lock <= lk;
    cmd_last <= ls;
    enhanced <= en;
    cmd_valid <= 1'b1;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (done_valid !== 1'b1 && n < 300);
    check(32'(n < 300), 32'h1);
    last_rd = done_rdata;
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clr();
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      a = {27'($random(seed)), 5'h00};
      d = $random(seed);
      clr();
      page_lock_scope <= 1'b0;
      cmd(atomic_pkg::OP_READ, a, d, 1'b1, 1'b0, 1'b0);
      check(last_rd, exp_rd(a));
      cmd(atomic_pkg::OP_WRITE, a, d, 1'b1, i == 0, 1'b0);
      shad[a] = d;
      if (i == 1)
      begin
        check(32'(pair_atomic), 32'h1);
        cmd(atomic_pkg::OP_WRITE, a, ~d, 1'b1, 1'b0, 1'b0);
        shad[a] = ~d;
        check(32'(pair_atomic), 32'h0);
      end
      check(32'(pa_seen), 32'h1);
      check(32'(priv_seen), 32'h1);
      check(32'(gl_seen), 32'h0);
      cmd(atomic_pkg::OP_READ, a, d, 1'b0, 1'b1, 1'b0);
      check(last_rd, exp_rd(a));
      $display("locked pair test %0d done", i);
    end
    page_lock_scope <= 1'b1;
    a = {27'($random(seed)), 5'h00};
    cmd(atomic_pkg::OP_READ, a, d, 1'b1, 1'b0, 1'b0);
    check(last_rd, exp_rd(a));
    cmd(atomic_pkg::OP_WRITE, a, d, 1'b1, 1'b0, 1'b0);
    shad[a] = d;
    check(32'(mem_global_lock), 32'h1);
    cmd(atomic_pkg::OP_WRITE, a + 32'h40, d, 1'b1, 1'b1, 1'b0);
    shad[a + 32'h40] = d;
    repeat (8) @(posedge core_clk);
    check(32'(mem_global_lock), 32'h0);
    $display("global lock test done");
    for (i = 0; i < 5; i++)
    begin
      a = {27'($random(seed)), 5'h00};
      d = $random(seed);
      page_lock_scope <= i[0];
      cmd(atomic_pkg::OP_WRITE, a, d, 1'b0, 1'b1, 1'b0);
      shad[a] = d;
      clr();
      cmd(atomic_pkg::OP_CLEAR, a, d, i[1], 1'b1, i < 4);
      check(last_rd, d);
      if (i < 4) shad[a] = 32'h0;
      check(32'(gl_seen), 32'h0);
      check(32'(priv_seen), 32'h1);
      check(32'(clr_cnt), 32'(i < 4));
      cmd(atomic_pkg::OP_READ, a, d, 1'b0, 1'b1, 1'b0);
      check(last_rd, exp_rd(a));
    end
    $display("clear test done");
    clr();
    for (i = 0; i < 60; i++)
    begin
      a = 32'h0000_1000 + 32'(($random(seed) & 15) << 2);
      d = $random(seed);
      page_lock_scope <= 1'($random(seed));
      cmd(d[0] ? atomic_pkg::OP_WRITE : atomic_pkg::OP_READ, a, d, 1'b0, 1'b1, 1'b0);
      if (d[0]) shad[a] = d;
      else check(last_rd, exp_rd(a));
    end
    check(32'(gl_seen), 32'h0);
    $display("random traffic test done");
    close_out();
  end
endmodule
